// *** hdl/nibble_add_sub_unit.sv ***
// Behaviour
// (RULE1) add-with-carry: memory nibble plus immediate plus carry, written back
// (RULE2) compare set: memory untouched, carry and zero still updated
// (RULE3) addition sets carry on overflow out of the nibble, else clears
// (RULE4) nonzero sum clears zero; zero sum sets it unless compare set
// (RULE5) addition is binary or decimal per the status word decimal bit
// (RULE6) word 0011_1000_1001_0000 increments the table address pointer
// (RULE7) table pointer is one value; carry ripples nibble to nibble
// (RULE8) table pointer width is a parameter
// (RULE9) word 0011_1000_1000_0000 increments the index pointer
// (RULE10) index pointer is 12 bits, carry low to mid to high nibble
// (RULE11) subtract: register minus memory nibble, written to the register
// (RULE12) compare set: register untouched, carry and zero still updated
// (RULE13) subtraction sets carry on borrow, else clears it
// (RULE14) nonzero difference clears zero; zero sets it unless compare set
// (RULE15) subtraction is binary or decimal per the status word decimal bit
// (RULE16) general register row chosen by the register pointer
// (RULE17) index enable modifies the memory operand address by the index
// (RULE18) modified address is index ORed with bank and operand bits
// (RULE19) nibble operands; carry from bit 3, low four bits written back
`timescale 1ns/10ps
`default_nettype none

`include "nibble_alu_regs.svh"

module nibble_add_sub_unit
	import nibble_alu_pkg::*;
#(
	parameter int TABLE_PTR_WIDTH = `TABLE_PTR_W
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire alu_cmd_s cmd_in,
	output logic cmd_ready_out,
	output logic done_out,
	input wire logic [`PSW_W-1:0] program_status_word_in,
	input wire logic index_modify_enable_in,
	input wire reg_pointer_s reg_pointer_in,
	output logic [`DM_ADDR_W-1:0] mem_addr_out,
	output logic mem_rd_out,
	input wire logic [`NIB_W-1:0] mem_rdata_in,
	output logic mem_we_out,
	output logic [`NIB_W-1:0] mem_wdata_out,
	input wire logic flag_load_in,
	input wire logic carry_load_in,
	input wire logic zero_load_in,
	output logic carry_borrow_flag_out,
	output logic zero_flag_out,
	input wire logic table_ptr_load_in,
	input wire logic [TABLE_PTR_WIDTH-1:0] table_ptr_load_data_in,
	output logic [TABLE_PTR_WIDTH-1:0] table_address_pointer_out,
	input wire logic index_ptr_load_in,
	input wire logic [`INDEX_PTR_W-1:0] index_ptr_load_data_in,
	output logic [`INDEX_PTR_W-1:0] index_pointer_out
);
	localparam int TABLE_NIBS = TABLE_PTR_WIDTH / `NIB_W;

	alu_state_e state_r;
	alu_state_e state_nxt;
	alu_cmd_s cmd_r;
	logic [`NIB_W-1:0] mem_operand_r;
	logic [`DM_ADDR_W-1:0] mem_addr_r;
	logic mem_rd_r;
	logic mem_we_r;
	logic [`NIB_W-1:0] mem_wdata_r;
	logic done_r;
	logic carry_r;
	logic zero_r;
	logic [TABLE_PTR_WIDTH-1:0] table_ptr_r;
	logic [`INDEX_PTR_W-1:0] index_ptr_r;

	logic accept_w;
	logic is_sys_w;
	logic is_arith_w;
	logic inc_table_w;
	logic inc_index_w;
	logic [`DM_ADDR_W-1:0] oper_addr_w;
	logic [`DM_ADDR_W-1:0] reg_addr_w;
	logic compare_w;
	logic decimal_w;
	logic subtract_w;
	logic [`NIB_W-1:0] alu_a_w;
	logic [`NIB_W-1:0] alu_b_w;
	logic [`NIB_W-1:0] alu_res_w;
	logic alu_carry_w;
	logic [TABLE_PTR_WIDTH-1:0] table_inc_w;
	logic [TABLE_NIBS:0] table_chain_w;
	logic [`INDEX_PTR_W-1:0] index_inc_w;
	logic [`NIB_W-1:0] index_pointer_low_nibble;
	logic [`NIB_W-1:0] index_pointer_mid_nibble;
	logic [`NIB_W-1:0] index_pointer_high_nibble;
	logic index_low_carry_w;
	logic index_mid_carry_w;

	// one command at a time; ready stays low through a whole add or subtract
	assign cmd_ready_out = (state_r == ST_IDLE);
	assign accept_w = cmd_valid_in && cmd_ready_out;
	assign is_sys_w = (cmd_in.op == OP_SYSTEM);
	// the spare operation code only completes, like a stray system word
	assign is_arith_w = (cmd_in.op == OP_ADD_IMM_CARRY) ||
		(cmd_in.op == OP_SUB_REG_MEM);
	assign inc_table_w = accept_w && is_sys_w &&
		(cmd_in.instr == `INSTR_INC_TABLE); // RULE6
	assign inc_index_w = accept_w && is_sys_w &&
		(cmd_in.instr == `INSTR_INC_INDEX); // RULE9

	// operand address, optionally merged with the index pointer
	always_comb begin
		oper_addr_w = {cmd_in.bank, cmd_in.oper_addr};
		if (index_modify_enable_in) begin
			oper_addr_w = oper_addr_w |
				index_ptr_r[`DM_ADDR_W-1:0]; // RULE17 RULE18
		end
	end

	// general register: pointer picks bank and row, command picks column
	assign reg_addr_w = {reg_pointer_in.register_pointer_high,
		reg_pointer_in.register_pointer_low[`NIB_W-1:1],
		cmd_r.reg_col}; // RULE16

	// operand steering for the shared nibble adder
	assign compare_w = program_status_word_in[`PSW_CMP_BIT];
	assign decimal_w = program_status_word_in[`PSW_BCD_BIT]; // RULE5 RULE15
	assign subtract_w = (cmd_r.op == OP_SUB_REG_MEM);

	always_comb begin
		if (subtract_w) begin
			alu_a_w = mem_rdata_in; // RULE11
			alu_b_w = mem_operand_r;
		end else begin
			alu_a_w = mem_rdata_in; // RULE1
			alu_b_w = cmd_r.imm;
		end
	end

	nibble_arith alu_core (
		.a_in(alu_a_w),
		.b_in(alu_b_w),
		.carry_in(subtract_w ? 1'b0 : carry_r),
		.subtract_in(subtract_w),
		.decimal_in(decimal_w),
		.result_out(alu_res_w),
		.carry_out(alu_carry_w)
	); // RULE19

	// pointer incrementers, one nibble stage per pointer nibble
	assign table_chain_w[0] = 1'b1;

	genvar gi;
	generate
		for (gi = 0; gi < TABLE_NIBS; gi = gi + 1) begin : g_table
			nibble_arith table_stage (
				.a_in(table_ptr_r[gi*`NIB_W +: `NIB_W]),
				.b_in(`NIB_ZERO),
				.carry_in(table_chain_w[gi]),
				.subtract_in(1'b0),
				.decimal_in(1'b0),
				.result_out(table_inc_w[gi*`NIB_W +: `NIB_W]),
				.carry_out(table_chain_w[gi+1])
			); // RULE7 RULE8
		end
	endgenerate

	// index pointer: three fixed stages, carry low to mid to high
	assign index_pointer_low_nibble = index_ptr_r[`NIB_W-1:0];
	assign index_pointer_mid_nibble = index_ptr_r[`NIB_W +: `NIB_W];
	assign index_pointer_high_nibble =
		index_ptr_r[`INDEX_PTR_W-`NIB_W +: `NIB_W];

	nibble_arith index_low_stage (
		.a_in(index_pointer_low_nibble),
		.b_in(`NIB_ZERO),
		.carry_in(1'b1),
		.subtract_in(1'b0),
		.decimal_in(1'b0),
		.result_out(index_inc_w[`NIB_W-1:0]),
		.carry_out(index_low_carry_w)
	); // RULE10

	nibble_arith index_mid_stage (
		.a_in(index_pointer_mid_nibble),
		.b_in(`NIB_ZERO),
		.carry_in(index_low_carry_w),
		.subtract_in(1'b0),
		.decimal_in(1'b0),
		.result_out(index_inc_w[`NIB_W +: `NIB_W]),
		.carry_out(index_mid_carry_w)
	); // RULE10

	// the top carry is dropped, so the pointer wraps to zero
	nibble_arith index_high_stage (
		.a_in(index_pointer_high_nibble),
		.b_in(`NIB_ZERO),
		.carry_in(index_mid_carry_w),
		.subtract_in(1'b0),
		.decimal_in(1'b0),
		.result_out(index_inc_w[`INDEX_PTR_W-`NIB_W +: `NIB_W]),
		.carry_out()
	); // RULE10

	// sequencer: add and subtract walk the states;
	// every other word completes without leaving idle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (accept_w && is_arith_w) begin
					state_nxt = ST_RD_MEM;
				end
			end
			ST_RD_MEM: begin
				if (subtract_w) begin
					state_nxt = ST_RD_REG;
				end else begin
					state_nxt = ST_EXEC;
				end
			end
			ST_RD_REG: begin
				state_nxt = ST_EXEC;
			end
			ST_EXEC: begin
				state_nxt = ST_WRITE;
			end
			ST_WRITE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// command capture
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cmd_r <= '0;
		end else if (accept_w) begin
			cmd_r <= cmd_in;
		end
	end

	// memory operand of a subtraction arrives while the register is read
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mem_operand_r <= `NIB_ZERO;
		end else if (state_r == ST_RD_REG) begin
			mem_operand_r <= mem_rdata_in;
		end
	end

	// memory port: address, read strobe, write strobe and data
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mem_addr_r <= `DM_ADDR_RST;
			mem_rd_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_wdata_r <= `NIB_ZERO;
		end else begin
			mem_rd_r <= 1'b0;
			mem_we_r <= 1'b0;
			if (accept_w && is_arith_w) begin
				mem_addr_r <= oper_addr_w;
				mem_rd_r <= 1'b1;
			end else if (state_r == ST_RD_MEM && subtract_w) begin
				mem_addr_r <= reg_addr_w;
				mem_rd_r <= 1'b1;
			end else if (state_r == ST_EXEC) begin
				// address still names the target: memory for add, register
				// for subtract; compare blocks only the store
				mem_we_r <= !compare_w; // RULE1 RULE2 RULE11 RULE12
				mem_wdata_r <= alu_res_w; // RULE19
			end
		end
	end

	// carry and zero flags; an arithmetic update beats an outside load
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			carry_r <= 1'b0;
			zero_r <= 1'b0;
		end else if (state_r == ST_EXEC) begin
			carry_r <= alu_carry_w; // RULE3 RULE13
			if (alu_res_w != `NIB_ZERO) begin
				zero_r <= 1'b0; // RULE4 RULE14
			end else if (!compare_w) begin
				zero_r <= 1'b1; // RULE4 RULE14
			end
		end else if (flag_load_in) begin
			carry_r <= carry_load_in;
			zero_r <= zero_load_in;
		end
	end

	// table address pointer; a load beats an increment
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			table_ptr_r <= TABLE_PTR_WIDTH'(`TABLE_PTR_RST);
		end else if (table_ptr_load_in) begin
			table_ptr_r <= table_ptr_load_data_in;
		end else if (inc_table_w) begin
			table_ptr_r <= table_inc_w; // RULE6 RULE7
		end
	end

	// index pointer; a load beats an increment
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			index_ptr_r <= `INDEX_PTR_RST;
		end else if (index_ptr_load_in) begin
			index_ptr_r <= index_ptr_load_data_in;
		end else if (inc_index_w) begin
			index_ptr_r <= index_inc_w; // RULE9 RULE10
		end
	end

	// completion: one cycle after a system word, or with the store cycle
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (accept_w && !is_arith_w) || (state_r == ST_EXEC);
		end
	end

	assign done_out = done_r;
	assign mem_addr_out = mem_addr_r;
	assign mem_rd_out = mem_rd_r;
	assign mem_we_out = mem_we_r;
	assign mem_wdata_out = mem_wdata_r;
	assign carry_borrow_flag_out = carry_r;
	assign zero_flag_out = zero_r;
	assign table_address_pointer_out = table_ptr_r;
	assign index_pointer_out = index_ptr_r;
endmodule

`default_nettype wire

// *** hdl/nibble_alu_regs.svh ***
`ifndef NIBBLE_ALU_REGS_SVH
`define NIBBLE_ALU_REGS_SVH

// operand and pointer widths
`define NIB_W 4
`define TABLE_PTR_W 16
`define INDEX_PTR_W 12
`define DM_ADDR_W 11
`define DM_BANK_W 4
`define DM_OPER_W 7
`define INSTR_W 16
`define PSW_W 4

// program status word bit positions
`define PSW_BCD_BIT 0
`define PSW_CMP_BIT 1

// system increment instruction words
`define INSTR_INC_TABLE 16'h3890
`define INSTR_INC_INDEX 16'h3880

// decimal correction
`define DEC_LIMIT 5'h09
`define DEC_ADJUST 4'h6

// reset values
`define TABLE_PTR_RST 16'h0000
`define INDEX_PTR_RST 12'h000
`define DM_ADDR_RST 11'h000
`define NIB_ZERO 4'h0

`endif

// *** hdl/nibble_alu_pkg.sv ***
`include "nibble_alu_regs.svh"

package nibble_alu_pkg;

	typedef enum logic [1:0] {
		OP_ADD_IMM_CARRY = 2'h0,
		OP_SUB_REG_MEM = 2'h1,
		OP_SYSTEM = 2'h2
	} alu_op_e;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RD_MEM = 5'h02,
		ST_RD_REG = 5'h04,
		ST_EXEC = 5'h08,
		ST_WRITE = 5'h10
	} alu_state_e;

	typedef struct packed {
		alu_op_e op;
		logic [`DM_BANK_W-1:0] bank;
		logic [`DM_OPER_W-1:0] oper_addr;
		logic [`NIB_W-1:0] imm;
		logic [`NIB_W-1:0] reg_col;
		logic [`INSTR_W-1:0] instr;
	} alu_cmd_s;

	typedef struct packed {
		logic [`NIB_W-1:0] register_pointer_high;
		logic [`NIB_W-1:0] register_pointer_low;
	} reg_pointer_s;

endpackage

// *** hdl/nibble_arith.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "nibble_alu_regs.svh"

module nibble_arith (
	input wire logic [`NIB_W-1:0] a_in,
	input wire logic [`NIB_W-1:0] b_in,
	input wire logic carry_in,
	input wire logic subtract_in,
	input wire logic decimal_in,
	output logic [`NIB_W-1:0] result_out,
	output logic carry_out
);
	logic [`NIB_W:0] sum_w;
	logic [`NIB_W:0] diff_w;

	// carry out of bit 3 is the carry or borrow, forced to 1 for a decimal sum above 9; only four bits kept
	always_comb begin
		sum_w = {1'b0, a_in} + {1'b0, b_in} + {{`NIB_W{1'b0}}, carry_in};
		diff_w = {1'b0, a_in} - {1'b0, b_in} - {{`NIB_W{1'b0}}, carry_in};
		if (subtract_in) begin
			carry_out = diff_w[`NIB_W];
			if (decimal_in && diff_w[`NIB_W]) begin
				result_out = diff_w[`NIB_W-1:0] - `DEC_ADJUST;
			end else begin
				result_out = diff_w[`NIB_W-1:0];
			end
		end else if (decimal_in && (sum_w > `DEC_LIMIT)) begin
			carry_out = 1'b1;
			result_out = sum_w[`NIB_W-1:0] + `DEC_ADJUST;
		end else begin
			carry_out = sum_w[`NIB_W];
			result_out = sum_w[`NIB_W-1:0];
		end
	end
endmodule

`default_nettype wire

// *** tb/add_sub_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module add_sub_monitor
	import nibble_alu_pkg::*;
#(
	parameter int TABLE_PTR_WIDTH = 16
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire alu_cmd_s cmd_in,
	input wire logic cmd_ready_out,
	input wire logic done_out,
	input wire logic [3:0] program_status_word_in,
	input wire logic index_modify_enable_in,
	input wire reg_pointer_s reg_pointer_in,
	input wire logic [10:0] mem_addr_out,
	input wire logic mem_rd_out,
	input wire logic mem_we_out,
	input wire logic [3:0] mem_wdata_out,
	input wire logic zero_flag_out,
	input wire logic table_ptr_load_in,
	input wire logic [TABLE_PTR_WIDTH-1:0] table_address_pointer_out,
	input wire logic index_ptr_load_in,
	input wire logic [11:0] index_pointer_out
);
	logic take, add, sub, sys, cmp, arith_r;
	logic [10:0] oper_a, reg_a;
	assign take = cmd_valid_in && cmd_ready_out;
	assign add = take && cmd_in.op == OP_ADD_IMM_CARRY;
	assign sub = take && cmd_in.op == OP_SUB_REG_MEM;
	assign sys = take && cmd_in.op == OP_SYSTEM;
	assign cmp = program_status_word_in[1];
	assign oper_a = {cmd_in.bank, cmd_in.oper_addr}
		| (index_modify_enable_in ? index_pointer_out[10:0] : 11'h0);
	assign reg_a = {reg_pointer_in[7:1], cmd_in.reg_col};
	// marks that the pending done belongs to an add or subtract
	always_ff @(posedge clock_in) begin
		if (rst_in)
			arith_r <= 1'b0;
		else if (take)
			arith_r <= add || sub;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	AST_OPER_RD: assert property (
		(add || sub) |=> mem_rd_out && !cmd_ready_out
			&& mem_addr_out == $past(oper_a)) else $error("operand read");
	AST_ADD_WR: assert property (
		add |-> ##3 done_out && mem_we_out == !cmp
			&& mem_addr_out == $past(oper_a, 3)) else $error("add write");
	AST_SUB_RD: assert property (
		sub |-> ##2 mem_rd_out && mem_addr_out == $past(reg_a, 2))
		else $error("register read");
	AST_SUB_WR: assert property (
		sub |-> ##4 done_out && mem_we_out == !cmp
			&& mem_addr_out == $past(reg_a, 4)) else $error("sub write");
	AST_INC_TBL: assert property (
		sys && cmd_in.instr == 16'h3890 && !table_ptr_load_in |=> done_out
			&& table_address_pointer_out
			== $past(table_address_pointer_out) + 1'b1)
		else $error("table increment");
	AST_INC_IDX: assert property (
		sys && cmd_in.instr == 16'h3880 && !index_ptr_load_in |=> done_out
			&& index_pointer_out == $past(index_pointer_out) + 1'b1)
		else $error("index increment");
	AST_ZERO_CLR: assert property (
		done_out && arith_r && mem_wdata_out != 4'h0 |-> !zero_flag_out)
		else $error("zero not cleared");
	AST_ZERO_SET: assert property (
		done_out && arith_r && mem_wdata_out == 4'h0 && !cmp |-> zero_flag_out)
		else $error("zero not set");
endmodule
bind nibble_add_sub_unit add_sub_monitor #(.TABLE_PTR_WIDTH(TABLE_PTR_WIDTH))
	i_add_sub_monitor (.clock_in, .rst_in, .cmd_valid_in, .cmd_in,
	.cmd_ready_out, .done_out, .program_status_word_in,
	.index_modify_enable_in, .reg_pointer_in, .mem_addr_out, .mem_rd_out,
	.mem_we_out, .mem_wdata_out, .zero_flag_out, .table_ptr_load_in,
	.table_address_pointer_out, .index_ptr_load_in, .index_pointer_out);
`default_nettype wire

// *** tb/dmem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dmem_model (
	input wire logic clock_in,
	input wire logic [10:0] addr_in,
	input wire logic rd_in,
	input wire logic we_in,
	input wire logic [3:0] wdata_in,
	output logic [3:0] rdata_out
);
	logic [3:0] mem [2048];
	initial rdata_out = 4'h0;
	// one cycle read latency; data lines toggle when no read is pending
	always @(posedge clock_in) begin
		rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
		if (we_in)
			mem[addr_in] <= wdata_in;
	end
endmodule
`default_nettype wire

// *** tb/nibble_add_sub_unit_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module nibble_add_sub_unit_tb;
	import nibble_alu_pkg::*;
	logic clock_in, rst_in = 1'b1, cmd_valid_in = 1'b0, flag_load_in = 1'b0;
	logic carry_load_in = 1'b0, zero_load_in = 1'b0, table_ptr_load_in = 1'b0;
	logic index_ptr_load_in = 1'b0, index_modify_enable_in = 1'b0;
	logic cmd_ready_out, done_out, mem_rd_out, mem_we_out, exp_c, exp_z;
	logic carry_borrow_flag_out, zero_flag_out;
	alu_cmd_s cmd_in = '0;
	reg_pointer_s reg_pointer_in = '0;
	logic [3:0] program_status_word_in = '0, mem_rdata_in, mem_wdata_out;
	logic [10:0] mem_addr_out;
	logic [15:0] table_ptr_load_data_in = '0, table_address_pointer_out;
	logic [11:0] index_ptr_load_data_in = '0, index_pointer_out;
	logic [15:0] exp_tbl;
	logic [11:0] exp_idx;
	int err_total, comparisons;
	nibble_add_sub_unit #(.TABLE_PTR_WIDTH(16)) i_nibble_add_sub_unit (
		.clock_in, .rst_in, .cmd_valid_in, .cmd_in, .cmd_ready_out, .done_out,
		.program_status_word_in, .index_modify_enable_in, .reg_pointer_in,
		.mem_addr_out, .mem_rd_out, .mem_rdata_in, .mem_we_out,
		.mem_wdata_out, .flag_load_in, .carry_load_in, .zero_load_in,
		.carry_borrow_flag_out, .zero_flag_out, .table_ptr_load_in,
		.table_ptr_load_data_in, .table_address_pointer_out,
		.index_ptr_load_in, .index_ptr_load_data_in, .index_pointer_out);
	dmem_model i_dmem_model (.clock_in, .addr_in(mem_addr_out),
		.rd_in(mem_rd_out), .we_in(mem_we_out), .wdata_in(mem_wdata_out),
		.rdata_out(mem_rdata_in));
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	function automatic logic [4:0] calc(logic [3:0] a, b, logic ci, sb, dc);
		logic [4:0] s;
		s = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + b + ci;
		if (dc && sb && s[4])
			s[3:0] = s[3:0] - 4'h6;
		if (dc && !sb && s > 5'h09)
			s = {1'b1, s[3:0] + 4'h6};
		return s;
	endfunction
	task automatic summarize;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic run(alu_cmd_s c);
		int n;
		n = 0;
		@(negedge clock_in);
		cmd_in = c;
		cmd_valid_in = 1'b1;
		@(negedge clock_in);
		cmd_valid_in = 1'b0;
		while (done_out !== 1'b1) begin
			@(negedge clock_in);
			n++;
			if (n > 9) begin
				err_total++;
				summarize();
			end
		end
	endtask
	task automatic load(logic [15:0] t, logic [11:0] x);
		table_ptr_load_in = 1'b1;
		index_ptr_load_in = 1'b1;
		table_ptr_load_data_in = t;
		index_ptr_load_data_in = x;
		@(negedge clock_in);
		table_ptr_load_in = 1'b0;
		index_ptr_load_in = 1'b0;
		exp_tbl = t;
		exp_idx = x;
	endtask
	task automatic inc(logic t);
		alu_cmd_s c;
		c = '0;
		c.op = OP_SYSTEM;
		c.instr = t ? 16'h3890 : 16'h3880;
		run(c);
		if (t)
			exp_tbl++;
		else
			exp_idx++;
		chk("tptr", exp_tbl, table_address_pointer_out);
		chk("iptr", 16'(exp_idx), 16'(index_pointer_out));
	endtask
	task automatic idle_word(alu_op_e o);
		alu_cmd_s c;
		c = '0;
		c.op = o;
		c.instr = 16'h3881;
		run(c);
		chk("tptr", exp_tbl, table_address_pointer_out);
		chk("iptr", 16'(exp_idx), 16'(index_pointer_out));
	endtask
	task automatic arith(logic sb);
		alu_cmd_s c;
		logic [10:0] oa, ra;
		logic [4:0] r;
		logic [3:0] m, g;
		logic cp, dc;
		int lim;
		c = alu_cmd_s'(37'({$urandom, $urandom}));
		c.op = sb ? OP_SUB_REG_MEM : OP_ADD_IMM_CARRY;
		dc = 1'($urandom_range(1));
		cp = 1'($urandom_range(1));
		lim = dc ? 9 : 15;
		c.imm = 4'($urandom_range(lim));
		program_status_word_in = {2'b00, cp, dc};
		index_modify_enable_in = 1'($urandom_range(1));
		reg_pointer_in = reg_pointer_s'(8'($urandom));
		flag_load_in = 1'b1;
		carry_load_in = 1'($urandom_range(1));
		zero_load_in = 1'($urandom_range(1));
		exp_c = carry_load_in;
		exp_z = zero_load_in;
		@(negedge clock_in);
		flag_load_in = 1'b0;
		oa = {c.bank, c.oper_addr} | (index_modify_enable_in ? exp_idx[10:0] : '0);
		ra = {reg_pointer_in[7:1], c.reg_col};
		i_dmem_model.mem[oa] = 4'($urandom_range(lim));
		i_dmem_model.mem[ra] = 4'($urandom_range(lim));
		m = i_dmem_model.mem[oa];
		g = i_dmem_model.mem[ra];
		r = sb ? calc(g, m, 1'b0, 1'b1, dc) : calc(m, c.imm, exp_c, 1'b0, dc);
		run(c);
		exp_c = r[4];
		exp_z = (r[3:0] != 4'h0) ? 1'b0 : (cp ? exp_z : 1'b1);
		chk("carry", 16'(exp_c), 16'(carry_borrow_flag_out));
		chk("zero", 16'(exp_z), 16'(zero_flag_out));
		@(negedge clock_in);
		chk("result", 16'(cp ? (sb ? g : m) : r[3:0]),
			16'(i_dmem_model.mem[sb ? ra : oa]));
	endtask
	initial begin
		void'($urandom(32'h4acf));
		repeat (6) @(negedge clock_in);
		rst_in = 1'b0;
		load(16'hffff, 12'h0ff);
		inc(1'b1);
		inc(1'b0);
		load(16'h0fff, 12'hfff);
		inc(1'b1);
		inc(1'b0);
		idle_word(OP_SYSTEM);
		idle_word(alu_op_e'(2'h3));
		repeat (300) begin
			inc(1'($urandom_range(1)));
			arith(1'b0);
			arith(1'b1);
		end
		summarize();
	end
endmodule
`default_nettype wire
